// ==== inc/swp_pkg.sv ====
// package: shared constants and types for the single-wire hold-off command block
// assumes: one 20 MHz clock, decoded command bytes arrive from logic on that clock
package swp_pkg;
   // ==========================================================
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned NS_PER_US = 1000;
   localparam int unsigned HOLD_OFF_TIME_US_DEFAULT = 1000;
   localparam int unsigned CNT_W = 32;

   // ==========================================================
   // command packet layout: opcode, first parameter, two-byte second parameter, no data
   localparam logic [7:0] SHORT_HOLD_OFF_OPCODE = 8'h00;
   localparam logic [2:0] PKT_LEN = 3'h4;
   localparam logic [2:0] OPCODE_POS = 3'h0;
   localparam logic [7:0] RESULT_SUCCESS = 8'h00;

   // ==========================================================
   // reset values
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [2:0] BYTE_CNT_RESET = 3'h0;
   localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      SWP_IDLE = 2'b00,
      SWP_HOLD = 2'b01,
      SWP_DONE = 2'b10
   } swp_state_type;
endpackage

// ==== inc/swp_wire_if.sv ====
// interface: link between the command handler and the single-wire pin front end
// assumes: both ends run on the same clock
`timescale 1ns/100ps
interface swp_wire_if;
   logic ignore;     // high while the wire must be disregarded
   logic pull_req;   // request to pull the wire low
   logic edge_seen;  // one-cycle pulse on a wire transition
   logic level;      // synchronised wire level
   modport ctrl (output ignore, output pull_req, input edge_seen, input level);
   modport pin (input ignore, input pull_req, output edge_seen, output level);
endinterface

// ==== rtl/swp_pin_front.sv ====
// pin front end: synchroniser, transition detector and open-drain driver for the wire
// assumes: the wire has an external pull-up; a testbench resolves the level from io_oe_out
`timescale 1ns/100ps
module swp_pin_front (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic io_in,
   output logic io_out,
   output logic io_oe_out,
   swp_wire_if.pin wire_if
);
   import swp_pkg::*;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic edge_seen;
      logic oe;
   } swp_front_type;

   swp_front_type front_q, front_d;

   // ==========================================================
   // next state
   always_comb begin
      front_d = front_q;
      front_d.sync1 = io_in;
      front_d.sync2 = front_q.sync1;
      front_d.prev = front_q.sync2;
      // transition pulses during the hold-off never reach the command logic; the synchronised level still does
      front_d.edge_seen = (front_q.sync2 != front_q.prev) && !wire_if.ignore;
      // only ever pull low or release; the high level comes from the pull-up
      front_d.oe = wire_if.pull_req && !wire_if.ignore;
   end

   // ==========================================================
   // registers; idle wire reads as pulled up
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         front_q <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, edge_seen: 1'b0, oe: 1'b0};
      end else begin
         front_q <= front_d;
      end
   end

   assign io_out = 1'b0;  // open drain: driven value is always low
   assign io_oe_out = front_q.oe;
   assign wire_if.edge_seen = front_q.edge_seen;
   assign wire_if.level = front_q.sync2;
endmodule

// ==== rtl/swp_hold_off_cmd.sv ====
// command handler for the short hold-off command of a single-wire device
// assumes: an upstream decoder on clk_in delivers command bytes and a packet-end strobe,
// and raises tx_flag_in when the host asks the device to transmit
//
// Operation
// - on the hold-off command go busy for the whole interval, then resume.
// - ignore every wire edge while the hold-off interval runs; wire_level_out still follows the wire.
// - the hold-off command is the opcode byte 0x00.
// - after the interval, answer the next transmit request with one zero byte.
// - the wire is open drain only: pull low or release, pull-up gives high.
`timescale 1ns/100ps
module swp_hold_off_cmd #(
   parameter int unsigned HOLD_OFF_TIME_US = swp_pkg::HOLD_OFF_TIME_US_DEFAULT
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic io_in,
   output logic io_out,
   output logic io_oe_out,
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   input wire logic pkt_end_in,
   input wire logic tx_flag_in,
   input wire logic pull_req_in,
   output logic busy_out,
   output logic resp_valid_out,
   output logic [7:0] resp_byte_out,
   output logic wire_edge_out,
   output logic wire_level_out
);
   import swp_pkg::*;

   // least time, so round the cycle count up
   localparam longint unsigned HOLD_OFF_NS = longint'(HOLD_OFF_TIME_US) * NS_PER_US;
   localparam longint unsigned HOLD_OFF_CYC_L = (HOLD_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] HOLD_OFF_CYCLES =
      (HOLD_OFF_CYC_L == 0) ? 32'h0000_0001 : HOLD_OFF_CYC_L[CNT_W-1:0];

   typedef struct packed {
      swp_state_type state;
      logic [2:0] byte_cnt;
      logic [7:0] opcode;
      logic [CNT_W-1:0] cnt;
      logic busy;
      logic resp_valid;
      logic [7:0] resp_byte;
      logic edge_seen;
      logic level;
   } swp_cmd_type;

   swp_cmd_type cmd_q, cmd_d;
   swp_wire_if wire_if ();

   function automatic logic is_hold_off(input logic [7:0] opc, input logic [2:0] cnt);
      // parameters are not checked: the host is trusted to send them as zero
      is_hold_off = (opc == SHORT_HOLD_OFF_OPCODE) && (cnt == PKT_LEN);
   endfunction

   // ==========================================================
   // command sequencing
   always_comb begin
      cmd_d = cmd_q;
      cmd_d.resp_valid = 1'b0;
      cmd_d.level = wire_if.level;
      case (cmd_q.state)
         SWP_IDLE: begin
            if (byte_valid_in) begin
               if (cmd_q.byte_cnt == OPCODE_POS) begin
                  cmd_d.opcode = byte_in;
               end
               // saturate so an overlong packet cannot wrap into a valid length
               if (cmd_q.byte_cnt != 3'h7) begin
                  cmd_d.byte_cnt = cmd_q.byte_cnt + 3'h1;
               end
            end
            if (pkt_end_in) begin
               cmd_d.byte_cnt = BYTE_CNT_RESET;
               if (is_hold_off(cmd_q.opcode, cmd_q.byte_cnt)) begin
                  cmd_d.state = SWP_HOLD;
                  cmd_d.busy = 1'b1;
                  cmd_d.cnt = HOLD_OFF_CYCLES;
               end
            end
         end
         SWP_HOLD: begin
            // every byte, strobe and transmit request is dropped here
            if (cmd_q.cnt == 32'h0000_0001) begin
               cmd_d.state = SWP_DONE;
               cmd_d.busy = 1'b0;
               cmd_d.cnt = CNT_RESET;
            end else begin
               cmd_d.cnt = cmd_q.cnt - 32'h0000_0001;
            end
         end
         SWP_DONE: begin
            if (tx_flag_in) begin
               cmd_d.resp_valid = 1'b1;
               cmd_d.resp_byte = RESULT_SUCCESS;
               cmd_d.state = SWP_IDLE;
            end
         end
         default: begin
            cmd_d.state = SWP_IDLE;
            cmd_d.busy = 1'b0;
         end
      endcase
      // an edge already in the front-end pipe must not surface once busy is up
      cmd_d.edge_seen = wire_if.edge_seen && !cmd_d.busy;
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cmd_q <= '{state: SWP_IDLE, byte_cnt: BYTE_CNT_RESET, opcode: BYTE_RESET, cnt: CNT_RESET,
                    busy: 1'b0, resp_valid: 1'b0, resp_byte: BYTE_RESET, edge_seen: 1'b0, level: 1'b1};
      end else begin
         cmd_q <= cmd_d;
      end
   end

   // ==========================================================
   // wire front end
   // next-state busy, so pull and edge are cut on the same edge that raises busy
   assign wire_if.ignore = cmd_d.busy;
   assign wire_if.pull_req = pull_req_in;

   swp_pin_front u_front (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .io_in(io_in),
      .io_out(io_out),
      .io_oe_out(io_oe_out),
      .wire_if(wire_if)
   );

   assign busy_out = cmd_q.busy;
   assign resp_valid_out = cmd_q.resp_valid;
   assign resp_byte_out = cmd_q.resp_byte;
   assign wire_edge_out = cmd_q.edge_seen;
   assign wire_level_out = cmd_q.level;
endmodule

// ==== tb/swp_hold_off_cmd_props.sv ====
// checker: port timing of the hold-off command block
// assumes: bound into swp_hold_off_cmd, one clock domain
`timescale 1ns/100ps
module swp_hold_off_cmd_props #(
   parameter int unsigned HOLD_OFF_TIME_US = 1
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic io_out,
   input wire logic io_oe_out,
   input wire logic pkt_end_in,
   input wire logic tx_flag_in,
   input wire logic busy_out,
   input wire logic resp_valid_out,
   input wire logic [7:0] resp_byte_out,
   input wire logic wire_edge_out
);
   import swp_pkg::*;
   localparam int HOLD_CYC = HOLD_OFF_TIME_US * NS_PER_US / CLK_PERIOD_NS;
   logic [15:0] cnt_q;
   logic done_q;
   // ==========
   // helpers
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q <= 16'h0000;
         done_q <= 1'b0;
      end else begin
         cnt_q <= busy_out ? cnt_q + 16'h0001 : 16'h0000;
         done_q <= $fell(busy_out) | (done_q & !resp_valid_out);
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);
   sequence s_asked;
      done_q && tx_flag_in;
   endsequence
   AST_HOLD_LEN: assert property ($fell(busy_out) |-> int'(cnt_q) == HOLD_CYC)
      else $error("hold length");
   AST_HOLD_CAUSE: assert property ($rose(busy_out) |-> $past(pkt_end_in))
      else $error("busy uncaused");
   AST_NO_EDGE: assert property (busy_out |-> !wire_edge_out)
      else $error("edge while busy");
   AST_RESP: assert property (s_asked |=> resp_valid_out && resp_byte_out == 8'h00)
      else $error("no zero result");
   AST_RESP_CAUSE: assert property (resp_valid_out |-> $past(tx_flag_in) && !$past(busy_out))
      else $error("unasked result");
   AST_OD_LOW: assert property (io_out == 1'b0)
      else $error("wire driven high");
   AST_OD_BUSY: assert property (busy_out |-> !io_oe_out)
      else $error("pull while busy");
endmodule

// ==== tb/swp_host_model.sv ====
// host side of the shared wire, with the pull-up
// assumes: every party only pulls low
`timescale 1ns/100ps
module swp_host_model (
   input wire logic host_pull_in,
   input wire logic dut_oe_in,
   output logic wire_out
);
   assign wire_out = !(host_pull_in || dut_oe_in);
endmodule

// ==== tb/tb_swp_hold_off_cmd.sv ====
// testbench: hold-off command block, bytes, flags and wire
// assumes: hold-off shortened to 1 us
`timescale 1ns/100ps
module tb_swp_hold_off_cmd;
   import swp_pkg::*;
   logic clk_in, arst_n_in, io_in, io_out, io_oe_out, byte_valid_in, pkt_end_in, tx_flag_in, pull_req_in;
   logic busy_out, resp_valid_out, wire_edge_out, wire_level_out, host_pull;
   logic [7:0] byte_in, resp_byte_out;
   int errors, comparisons;
   swp_hold_off_cmd #(.HOLD_OFF_TIME_US(1)) i_dut (.clk_in, .arst_n_in, .io_in, .io_out, .io_oe_out,
      .byte_valid_in, .byte_in, .pkt_end_in, .tx_flag_in, .pull_req_in, .busy_out, .resp_valid_out,
      .resp_byte_out, .wire_edge_out, .wire_level_out);
   swp_host_model i_host (.host_pull_in(host_pull), .dut_oe_in(io_oe_out), .wire_out(io_in));
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wait_hi(input int w);
      for (int k = 0; k < 8 && (w == 0 ? busy_out : w == 1 ? resp_valid_out : wire_edge_out) !== 1'b1; k++)
         @(negedge clk_in);
      chk(8'(w == 0 ? busy_out : w == 1 ? resp_valid_out : wire_edge_out), 8'h01, "timeout");
      if (errors != 0) finish_test();
   endtask
   // params are zero and no data follows
   task automatic send_pkt(input logic [7:0] op, input int n, input logic wig);
      for (int i = 0; i < n; i++) begin
         byte_valid_in = 1'b1;
         byte_in = (i == 0) ? op : 8'h00;
         // a wire edge this late reaches the edge detector just as busy rises
         if (wig && i == 2) host_pull = 1'b1;
         @(negedge clk_in);
      end
      byte_valid_in = 1'b0;
      pkt_end_in = 1'b1;
      @(negedge clk_in);
      pkt_end_in = 1'b0;
   endtask
   task automatic sc_refuse();
      tx_flag_in = 1'b1;
      repeat (2) begin
         @(negedge clk_in);
         tx_flag_in = 1'b0;
         chk(8'(resp_valid_out), 8'h00, "early result");
      end
      send_pkt(8'h01, 4, 1'b0);
      send_pkt(SHORT_HOLD_OFF_OPCODE, 3, 1'b0);
      repeat (3) begin
         @(negedge clk_in);
         chk(8'(busy_out), 8'h00, "wrong packet taken");
      end
   endtask
   task automatic sc_wire();
      host_pull = 1'b1;
      wait_hi(2);
      chk(8'(wire_level_out), 8'h00, "wire level low");
      host_pull = 1'b0;
      pull_req_in = 1'b1;
      @(negedge clk_in);
      chk(8'({io_oe_out, io_in, io_out}), 8'h04, "open drain");
      pull_req_in = 1'b0;
      repeat (8) @(negedge clk_in);
   endtask
   task automatic sc_hold();
      int n;
      n = 0;
      send_pkt(SHORT_HOLD_OFF_OPCODE, 4, 1'b1);
      wait_hi(0);
      while (busy_out === 1'b1 && n < 64) begin
         host_pull = n[1];
         tx_flag_in = (n == 4);
         chk(8'({wire_edge_out, resp_valid_out, io_oe_out}), 8'h00, "busy activity");
         @(negedge clk_in);
         n++;
      end
      chk(8'(n), 8'(NS_PER_US / CLK_PERIOD_NS), "hold length");
      host_pull = 1'b0;
      @(negedge clk_in);
      tx_flag_in = 1'b1;
      @(negedge clk_in);
      tx_flag_in = 1'b0;
      wait_hi(1);
      chk(resp_byte_out, 8'h00, "result byte");
   endtask
   // pull request held across the command start, then a reset in mid hold-off
   task automatic sc_reset();
      pull_req_in = 1'b1;
      send_pkt(SHORT_HOLD_OFF_OPCODE, 4, 1'b0);
      chk(8'({busy_out, io_oe_out}), 8'h02, "pull at hold start");
      arst_n_in = 1'b0;
      pull_req_in = 1'b0;
      @(negedge clk_in);
      chk(8'({busy_out, resp_valid_out, io_oe_out, wire_edge_out, wire_level_out}), 8'h01, "reset values");
      arst_n_in = 1'b1;
      @(negedge clk_in);
      chk(8'({busy_out, wire_level_out}), 8'h01, "hold after reset");
   endtask
   initial begin
      {arst_n_in, byte_valid_in, pkt_end_in, tx_flag_in, pull_req_in, host_pull} = 6'h00;
      byte_in = 8'h00;
      errors = 0;
      comparisons = 0;
      repeat (10) @(negedge clk_in);
      arst_n_in = 1'b1;
      @(negedge clk_in);
      sc_refuse();
      sc_wire();
      sc_hold();
      sc_reset();
      finish_test();
   end
endmodule
bind swp_hold_off_cmd swp_hold_off_cmd_props #(.HOLD_OFF_TIME_US(HOLD_OFF_TIME_US)) i_props (.clk_in, .arst_n_in,
   .io_out, .io_oe_out, .pkt_end_in, .tx_flag_in, .busy_out, .resp_valid_out, .resp_byte_out, .wire_edge_out);
